// file: design/racac_map.svh
// Register map, field positions, reset values and timing constants
`ifndef RACAC_MAP_SVH
`define RACAC_MAP_SVH
`define RC_AXCFG4 8'h00
`define RC_AXCFG5 8'h04
`define RC_WRAP 8'h08
`define RC_CTRL 8'h0c
`define RC_MOVE 8'h10
`define RC_TRAVEL 8'h14
`define RC_LASH 8'h18
`define RC_ACCEL 8'h1c
`define RC_STATUS 8'h20
`define RC_ALARM 8'h24
`define RC_ABS 8'h28
`define RC_REL 8'h2c
`define RC_MACH 8'h30
`define RC_ROT 0
`define RC_ROS 1
`define RC_CSEN 5
`define RC_ROA 0
`define RC_RAB 1
`define RC_RRL 2
`define RC_RRT 6
`define RC_START 0
`define RC_DIR 1
`define RC_AHOME 2
`define RC_ALM_SW 0
`define RC_ALM_SPD 1
`define RC_ALM_REF 2
`define RC_ALM_BSY 3
`define RC_CFG_RST 8'h00
`define RC_TRAVEL_RST 32'h00008ca0
`define RC_LASH_RST 16'h0000
`define RC_ACCEL_RST 13'h0064
`define RC_ACCEL_MIN 13'h000a
`define RC_ACCEL_MAX 13'h0fa0
`define RC_PCLK_HZ 250000000
`define RC_PULSE_MAX_HZ 2000000
`endif

// file: design/racac_pkg.sv
// Types shared by the rotary and contour axis controller
package racac_pkg;
  typedef enum logic [1:0] {
    RACAC_LIN, RACAC_ROT_A, RACAC_ROT_B, RACAC_BAD
  } racac_axtype_t;
  typedef enum logic [2:0] {
    RACAC_IDLE, RACAC_LASH, RACAC_MOVE, RACAC_HRAPID,
    RACAC_HTRAIL, RACAC_HSLOW, RACAC_AMID, RACAC_ARET
  } racac_st_t;
  // Axis type pair decode
  function automatic racac_axtype_t racac_decode(input logic ros,
                                                 input logic rot);
    racac_axtype_t t;
    t = RACAC_BAD;
    case ({ros, rot})
      2'h0: t = RACAC_LIN;
      2'h1: t = RACAC_ROT_A;
      2'h3: t = RACAC_ROT_B;
      default: t = RACAC_BAD;
    endcase
    return t;
  endfunction
endpackage

// file: design/racac_top.sv
// Rotary and contour axis controller with APB register slave
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/1ns
`include "racac_map.svh"
module racac_top #(
  parameter int RAPID_PER = 125,
  parameter int LOW_PER = 2500
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic one_turn_pulse,
  input wire logic contour_mode_request,
  input wire logic jog_plus_sel,
  input wire logic jog_minus_sel,
  input wire logic homing_mode,
  input wire logic spindle_moving,
  output logic cmd_pulse,
  output logic cmd_dir,
  output logic contour_mode_ack,
  output logic spindle_stop_req,
  output logic home_done_flag
);
  localparam int MIN_PER =
    (`RC_PCLK_HZ + `RC_PULSE_MAX_HZ - 1) / `RC_PULSE_MAX_HZ;
  localparam logic [15:0] RAPID_LD = 16'(RAPID_PER - 1);
  localparam logic [15:0] LOW_LD = 16'(LOW_PER - 1);

  localparam bit PER_BAD =
    RAPID_PER < MIN_PER || LOW_PER < RAPID_PER || LOW_PER > 65536;

  if (PER_BAD) begin : g_chk
    $error("racac_top: pulse period out of range");
  end

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [5:0] raw;
  logic [5:0] sy1_ff;
  logic [5:0] sy2_ff;
  logic [5:0] sy3_ff;
  logic [5:0] syst_ff;
  logic [5:0] nxt_syst;
  assign raw = {spindle_moving, homing_mode, jog_minus_sel,
                jog_plus_sel, contour_mode_request, one_turn_pulse};

  for (genvar i = 0; i < 6; i++) begin : g_sync
    // Change accepted once second and third stage agree
    assign nxt_syst[i] = (sy2_ff[i] == sy3_ff[i]) ? sy3_ff[i] :
                         syst_ff[i];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sy1_ff <= '0;
      sy2_ff <= '0;
      sy3_ff <= '0;
      syst_ff <= '0;
    end else begin
      sy1_ff <= raw;
      sy2_ff <= sy1_ff;
      sy3_ff <= sy2_ff;
      syst_ff <= nxt_syst;
    end
  end

  logic pc_rise;
  logic pc_fall;
  logic req_st;
  logic jp_rise;
  logic jm_rise;
  logic hm_st;
  logic mov_st;
  assign pc_rise = nxt_syst[0] & ~syst_ff[0];
  assign pc_fall = ~nxt_syst[0] & syst_ff[0];
  assign req_st = syst_ff[1];
  assign jp_rise = nxt_syst[2] & ~syst_ff[2];
  assign jm_rise = nxt_syst[3] & ~syst_ff[3];
  assign hm_st = syst_ff[4];
  assign mov_st = syst_ff[5];

  // ---------------------------------------------------------------
  // Register file and APB slave
  // ---------------------------------------------------------------
  logic [7:0] cfg4_ff, nxt_cfg4;
  logic [7:0] cfg5_ff, nxt_cfg5;
  logic [7:0] wrap_ff, nxt_wrap;
  logic [31:0] move_ff, nxt_move;
  logic [31:0] travel_ff, nxt_travel;
  logic [15:0] lashreg_ff, nxt_lashreg;
  logic [12:0] accel_ff, nxt_accel;
  logic [3:0] alm_ff, nxt_alm;
  logic [3:0] evt;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  logic [31:0] prdata_ff, nxt_prdata;
  logic [31:0] rd;
  logic rd_err;
  logic wr;
  logic start_cmd;
  logic ahome_cmd;
  logic [31:0] status;
  logic signed [31:0] abs_ff, rel_ff, mach_ff;

  assign wr = psel & penable & pready_ff & pwrite;
  assign start_cmd = wr && paddr == `RC_CTRL && pwdata[`RC_START];
  assign ahome_cmd = wr && paddr == `RC_CTRL && pwdata[`RC_AHOME];

  always_comb begin
    rd = '0;
    rd_err = 1'b0;
    case (paddr)
      `RC_AXCFG4: rd = {24'h0, cfg4_ff};
      `RC_AXCFG5: rd = {24'h0, cfg5_ff};
      `RC_WRAP: rd = {24'h0, wrap_ff};
      `RC_CTRL: rd = '0;
      `RC_MOVE: rd = move_ff;
      `RC_TRAVEL: rd = travel_ff;
      `RC_LASH: rd = {16'h0, lashreg_ff};
      `RC_ACCEL: rd = {19'h0, accel_ff};
      `RC_STATUS: rd = status;
      `RC_ALARM: rd = {28'h0, alm_ff};
      `RC_ABS: rd = abs_ff;
      `RC_REL: rd = rel_ff;
      `RC_MACH: rd = mach_ff;
      default: rd_err = 1'b1;
    endcase
    nxt_pready = psel & penable & ~pready_ff;
    nxt_prdata = (nxt_pready && !pwrite) ? rd : '0;
    nxt_pslverr = nxt_pready & rd_err;
    nxt_cfg4 = cfg4_ff;
    nxt_cfg5 = cfg5_ff;
    nxt_wrap = wrap_ff;
    nxt_move = move_ff;
    nxt_travel = travel_ff;
    nxt_lashreg = lashreg_ff;
    nxt_accel = accel_ff;
    nxt_alm = alm_ff;
    if (wr) begin
      case (paddr)
        `RC_AXCFG4: nxt_cfg4 = pwdata[7:0];
        `RC_AXCFG5: nxt_cfg5 = pwdata[7:0];
        `RC_WRAP: nxt_wrap = pwdata[7:0];
        `RC_MOVE: nxt_move = pwdata;
        `RC_TRAVEL: if (pwdata != '0) nxt_travel = pwdata;
        `RC_LASH: nxt_lashreg = pwdata[15:0];
        `RC_ACCEL: begin
          if (pwdata < {19'h0, `RC_ACCEL_MIN})
            nxt_accel = `RC_ACCEL_MIN;
          else if (pwdata > {19'h0, `RC_ACCEL_MAX})
            nxt_accel = `RC_ACCEL_MAX;
          else
            nxt_accel = pwdata[12:0];
        end
        `RC_ALARM: nxt_alm = alm_ff & ~pwdata[3:0];
        default: ;
      endcase
    end
    // New alarm events win over a clear in the same cycle
    nxt_alm = nxt_alm | evt;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg4_ff <= `RC_CFG_RST;
      cfg5_ff <= `RC_CFG_RST;
      wrap_ff <= `RC_CFG_RST;
      move_ff <= '0;
      travel_ff <= `RC_TRAVEL_RST;
      lashreg_ff <= `RC_LASH_RST;
      accel_ff <= `RC_ACCEL_RST;
      alm_ff <= '0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end else begin
      cfg4_ff <= nxt_cfg4;
      cfg5_ff <= nxt_cfg5;
      wrap_ff <= nxt_wrap;
      move_ff <= nxt_move;
      travel_ff <= nxt_travel;
      lashreg_ff <= nxt_lashreg;
      accel_ff <= nxt_accel;
      alm_ff <= nxt_alm;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff <= nxt_prdata;
    end
  end

  // ---------------------------------------------------------------
  // Axis configuration decode
  // ---------------------------------------------------------------
  racac_pkg::racac_axtype_t t4, t5;
  logic rot4, rot5, cs4, cs5, d_sel;
  logic abs_wrap, rel_wrap, mach_wrap;
  assign t4 = racac_pkg::racac_decode(cfg4_ff[`RC_ROS],
                                      cfg4_ff[`RC_ROT]);
  assign t5 = racac_pkg::racac_decode(cfg5_ff[`RC_ROS],
                                      cfg5_ff[`RC_ROT]);
  assign rot4 = t4 == racac_pkg::RACAC_ROT_A ||
                t4 == racac_pkg::RACAC_ROT_B;
  assign rot5 = t5 == racac_pkg::RACAC_ROT_A ||
                t5 == racac_pkg::RACAC_ROT_B;
  // Contour axis on one rotary axis only, fourth axis first
  assign cs4 = rot4 & cfg4_ff[`RC_CSEN];
  assign cs5 = rot5 & cfg5_ff[`RC_CSEN] & ~cs4;
  assign d_sel = wrap_ff[`RC_RRT] & rot5;
  assign abs_wrap = rot5 & wrap_ff[`RC_ROA];
  assign rel_wrap = rot5 & wrap_ff[`RC_RRL];
  assign mach_wrap = t5 == racac_pkg::RACAC_ROT_A;

  // One count is 0.01 degree; wrap keeps the value in one turn
  function automatic logic signed [31:0] adv(
    input logic signed [31:0] c, input logic up, input logic w,
    input logic signed [31:0] tr);
    logic signed [31:0] n;
    n = up ? c + 32'sh1 : c - 32'sh1;
    if (w && n >= tr)
      n = 32'sh0;
    else if (w && n < 32'sh0)
      n = tr - 32'sh1;
    return n;
  endfunction

  // ---------------------------------------------------------------
  // Motion, homing and mode switch
  // ---------------------------------------------------------------
  racac_pkg::racac_st_t st_ff, nxt_st, ret_ff, nxt_ret, go_st;
  logic [31:0] cnt_ff, nxt_cnt;
  logic [15:0] lcnt_ff, nxt_lcnt;
  logic [15:0] per_ff, nxt_per;
  logic dir_ff, nxt_dir, ldir_ff, nxt_ldir, go, go_dir;
  logic pulse_ff, nxt_pulse, done_ff, nxt_done;
  logic ack_ff, nxt_ack, stop_ff, nxt_stop, unref_ff, nxt_unref;
  logic signed [31:0] nxt_abs, nxt_rel, nxt_mach;
  logic step, mv, fast, fin, want_ret, hreq;

  assign status = {24'h0, unref_ff, stop_ff, done_ff, ack_ff,
                   st_ff != racac_pkg::RACAC_IDLE, d_sel, cs5, cs4};

  always_comb begin
    nxt_st = st_ff;
    nxt_ret = ret_ff;
    nxt_cnt = cnt_ff;
    nxt_lcnt = lcnt_ff;
    nxt_dir = dir_ff;
    nxt_ldir = ldir_ff;
    nxt_done = done_ff;
    nxt_ack = ack_ff;
    nxt_unref = unref_ff;
    nxt_stop = 1'b0;
    nxt_pulse = 1'b0;
    nxt_abs = abs_ff;
    nxt_rel = rel_ff;
    nxt_mach = mach_ff;
    evt = '0;
    go = 1'b0;
    go_dir = dir_ff;
    go_st = st_ff;
    fin = 1'b0;
    want_ret = 1'b0;
    hreq = hm_st && (jp_rise || jm_rise);
    fast = st_ff != racac_pkg::RACAC_HTRAIL &&
           st_ff != racac_pkg::RACAC_HSLOW;
    // Pulse spacing never below the shortest legal period
    step = per_ff == '0 && st_ff != racac_pkg::RACAC_IDLE;
    mv = step && st_ff != racac_pkg::RACAC_LASH;
    nxt_per = per_ff;
    if (per_ff != '0)
      nxt_per = per_ff - 16'h0001;
    else if (step)
      nxt_per = fast ? RAPID_LD : LOW_LD;
    if (step)
      nxt_pulse = 1'b1;
    if (mv) begin
      nxt_abs = adv(abs_ff, dir_ff, abs_wrap, $signed(travel_ff));
      nxt_rel = adv(rel_ff, dir_ff, rel_wrap, $signed(travel_ff));
      nxt_mach = adv(mach_ff, dir_ff, mach_wrap,
                     $signed(travel_ff));
    end
    if (req_st && !ack_ff) begin
      if (mov_st) begin
        nxt_stop = 1'b1;
      end else begin
        nxt_ack = 1'b1;
        nxt_unref = 1'b1;
        nxt_done = 1'b0;
      end
    end else if (!req_st && ack_ff) begin
      nxt_ack = 1'b0;
      if (mov_st || st_ff != racac_pkg::RACAC_IDLE)
        evt[`RC_ALM_SW] = 1'b1;
    end
    unique case (st_ff)
      racac_pkg::RACAC_IDLE: begin
        if ((start_cmd || ahome_cmd || hreq) && cs5 && !ack_ff) begin
          evt[`RC_ALM_SPD] = 1'b1;
        end else if (hreq) begin
          // Method D homes in the positive direction only
          if (!d_sel || jp_rise) begin
            go = 1'b1;
            go_dir = jp_rise;
            go_st = racac_pkg::RACAC_HRAPID;
          end
        end else if (start_cmd && cs5 && unref_ff) begin
          evt[`RC_ALM_REF] = 1'b1;
        end else if (start_cmd && move_ff != '0) begin
          go = 1'b1;
          go_dir = pwdata[`RC_DIR];
          go_st = racac_pkg::RACAC_MOVE;
          nxt_cnt = move_ff;
        end else if (ahome_cmd) begin
          if (move_ff != '0) begin
            go = 1'b1;
            go_dir = pwdata[`RC_DIR];
            go_st = racac_pkg::RACAC_AMID;
            nxt_cnt = move_ff;
          end else begin
            want_ret = 1'b1;
          end
        end
      end
      racac_pkg::RACAC_LASH: begin
        if (step) begin
          nxt_lcnt = lcnt_ff - 16'h0001;
          if (lcnt_ff == 16'h0001)
            nxt_st = ret_ff;
        end
      end
      racac_pkg::RACAC_MOVE: begin
        if (step) begin
          nxt_cnt = cnt_ff - 32'h1;
          if (cnt_ff == 32'h1)
            nxt_st = racac_pkg::RACAC_IDLE;
        end
      end
      racac_pkg::RACAC_AMID: begin
        if (step) begin
          nxt_cnt = cnt_ff - 32'h1;
          if (cnt_ff == 32'h1)
            want_ret = 1'b1;
        end
      end
      racac_pkg::RACAC_ARET: begin
        if (mv && nxt_mach == 32'sh0)
          fin = 1'b1;
      end
      racac_pkg::RACAC_HRAPID: begin
        if (pc_rise) begin
          if (d_sel)
            nxt_st = racac_pkg::RACAC_HTRAIL;
          else
            fin = 1'b1;
        end
      end
      racac_pkg::RACAC_HTRAIL: begin
        if (pc_fall)
          nxt_st = racac_pkg::RACAC_HSLOW;
      end
      racac_pkg::RACAC_HSLOW: begin
        if (pc_rise)
          fin = 1'b1;
      end
    endcase
    if (st_ff != racac_pkg::RACAC_IDLE && (start_cmd || ahome_cmd))
      evt[`RC_ALM_BSY] = 1'b1;
    if (want_ret) begin
      if (nxt_mach == 32'sh0) begin
        fin = 1'b1;
      end else begin
        go = 1'b1;
        go_dir = nxt_mach < 32'sh0;
        go_st = racac_pkg::RACAC_ARET;
      end
    end
    if (go) begin
      nxt_dir = go_dir;
      nxt_ldir = go_dir;
      // Reversal inserts backlash pulses that leave coordinates alone
      if (go_dir != ldir_ff && lashreg_ff != '0) begin
        nxt_st = racac_pkg::RACAC_LASH;
        nxt_ret = go_st;
        nxt_lcnt = lashreg_ff;
      end else begin
        nxt_st = go_st;
      end
    end
    if (fin) begin
      nxt_st = racac_pkg::RACAC_IDLE;
      nxt_done = 1'b1;
      nxt_unref = 1'b0;
      nxt_abs = 32'sh0;
      nxt_rel = 32'sh0;
      nxt_mach = 32'sh0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= racac_pkg::RACAC_IDLE;
      ret_ff <= racac_pkg::RACAC_IDLE;
      cnt_ff <= '0;
      lcnt_ff <= '0;
      per_ff <= '0;
      dir_ff <= 1'b1;
      ldir_ff <= 1'b1;
      pulse_ff <= 1'b0;
      done_ff <= 1'b0;
      ack_ff <= 1'b0;
      stop_ff <= 1'b0;
      unref_ff <= 1'b0;
      abs_ff <= '0;
      rel_ff <= '0;
      mach_ff <= '0;
    end else begin
      st_ff <= nxt_st;
      ret_ff <= nxt_ret;
      cnt_ff <= nxt_cnt;
      lcnt_ff <= nxt_lcnt;
      per_ff <= nxt_per;
      dir_ff <= nxt_dir;
      ldir_ff <= nxt_ldir;
      pulse_ff <= nxt_pulse;
      done_ff <= nxt_done;
      ack_ff <= nxt_ack;
      stop_ff <= nxt_stop;
      unref_ff <= nxt_unref;
      abs_ff <= nxt_abs;
      rel_ff <= nxt_rel;
      mach_ff <= nxt_mach;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign cmd_pulse = pulse_ff;
  assign cmd_dir = dir_ff;
  assign contour_mode_ack = ack_ff;
  assign spindle_stop_req = stop_ff;
  assign home_done_flag = done_ff;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic [15:0] gap_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      gap_ff <= 16'hffff;
    else if (pulse_ff)
      gap_ff <= '0;
    else if (gap_ff != 16'hffff)
      gap_ff <= gap_ff + 16'h0001;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  pulse_gap_a: assert property (
    pulse_ff |-> gap_ff >= 16'(MIN_PER - 1))
    else $error("command pulses too close");
  abs_wrap_a: assert property (
    mv && abs_wrap && abs_ff >= 32'sh0 && abs_ff < $signed(travel_ff)
    && !fin |=> abs_ff >= 32'sh0 && abs_ff < $signed($past(travel_ff)))
    else $error("absolute coordinate left one turn");
  mach_lin_a: assert property (
    mv && !mach_wrap && dir_ff && !fin
    |=> mach_ff == $past(mach_ff) + 32'sh1)
    else $error("unwrapped machine coordinate did not count");
  d_ignore_a: assert property (
    !rot5 && st_ff == racac_pkg::RACAC_HRAPID
    |-> ##1 st_ff != racac_pkg::RACAC_HTRAIL)
    else $error("method D used on a non-rotary axis");
  trail_a: assert property (
    st_ff == racac_pkg::RACAC_HRAPID && pc_rise && d_sel
    |=> st_ff == racac_pkg::RACAC_HTRAIL ##0 !fast)
    else $error("no slow-down on first one-turn pulse");
  stop_home_a: assert property (
    st_ff == racac_pkg::RACAC_HSLOW && pc_rise
    |=> st_ff == racac_pkg::RACAC_IDLE && done_ff ##1 !pulse_ff)
    else $error("homing did not stop on one-turn pulse");
  ack_still_a: assert property (
    $rose(ack_ff) |-> !$past(mov_st) && !stop_ff)
    else $error("contour entered while spindle turning");
  unref_a: assert property (
    $rose(ack_ff) |-> unref_ff && !done_ff)
    else $error("position not marked unknown on contour entry");
  spd_refuse_a: assert property (
    st_ff == racac_pkg::RACAC_IDLE && start_cmd && cs5 && !ack_ff
    |=> st_ff == racac_pkg::RACAC_IDLE && alm_ff[`RC_ALM_SPD])
    else $error("contour motion not refused in speed mode");
  ack_track_a: assert property (
    !req_st && ack_ff |=> !ack_ff)
    else $error("acknowledge stayed high in speed mode");
  accel_rng_a: assert property (
    accel_ff >= `RC_ACCEL_MIN && accel_ff <= `RC_ACCEL_MAX)
    else $error("acceleration constant out of range");
  pc_once_a: assert property (
    pc_rise |=> !pc_rise [*2])
    else $error("one-turn edge counted twice");
endmodule

// file: bench/racac_drive.sv
// Spindle servo drive model: one-turn pulse and spindle motion report
`timescale 1ns/1ns
module racac_drive #(
  parameter int PPR = 4
) (
  input wire logic pclk,
  input wire logic cmd_pulse,
  input wire logic spindle_stop_req,
  input wire logic spin_cmd,
  output logic one_turn_pulse,
  output logic spindle_moving
);
  int cnt = 0;
  logic stopped = 1'b0;
  always @(posedge pclk) begin
    if (cmd_pulse === 1'b1) cnt <= (cnt == 2 * PPR - 1) ? 0 : cnt + 1;
    if (spindle_stop_req === 1'b1) stopped <= 1'b1;
    else if (spin_cmd == 1'b0) stopped <= 1'b0;
  end
  // Half a turn low, half a turn high
  assign one_turn_pulse = (cnt >= PPR);
  assign spindle_moving = spin_cmd & ~stopped;
endmodule

// file: bench/tb.sv
// Self-checking testbench for the rotary and contour axis controller
`timescale 1ns/1ns
`include "racac_map.svh"
module tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, one_turn_pulse, spindle_moving, spin_cmd = 0;
  logic contour_mode_request = 0, jog_plus_sel = 0, jog_minus_sel = 0;
  logic homing_mode = 0, cmd_pulse, cmd_dir, contour_mode_ack;
  logic spindle_stop_req, home_done_flag;
  int err_total = 0, num_checks = 0, cyc = 0;
  int pq[$];
  racac_top #(.RAPID_PER(125), .LOW_PER(200)) dut_u (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .one_turn_pulse(one_turn_pulse),
    .contour_mode_request(contour_mode_request),
    .jog_plus_sel(jog_plus_sel), .jog_minus_sel(jog_minus_sel),
    .homing_mode(homing_mode), .spindle_moving(spindle_moving),
    .cmd_pulse(cmd_pulse), .cmd_dir(cmd_dir),
    .contour_mode_ack(contour_mode_ack),
    .spindle_stop_req(spindle_stop_req), .home_done_flag(home_done_flag));
  racac_drive #(.PPR(4)) drv_u (.pclk(pclk), .cmd_pulse(cmd_pulse),
    .spindle_stop_req(spindle_stop_req), .spin_cmd(spin_cmd),
    .one_turn_pulse(one_turn_pulse), .spindle_moving(spindle_moving));
  // ----------------------------------------
  // Clock, pulse log, bus tasks
  // ----------------------------------------
  initial forever #2 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cmd_pulse === 1'b1) pq.push_back(cyc);
  end
  task automatic cmp(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input string n, input logic [7:0] a,
                     input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    cmp(n, e, rd);
  endtask
  task automatic idle();
    for (int i = 0; i < 300; i++) begin
      apb(1'b0, `RC_STATUS, 32'h0);
      if (rd[3] === 1'b0) break;
    end
    cmp("busy", 32'h0, {31'h0, rd[3]});
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    rdc("axcfg4", `RC_AXCFG4, 32'h0);
    rdc("travel", `RC_TRAVEL, 32'h8ca0);
    wr(`RC_ACCEL, 32'h2);
    rdc("accel", `RC_ACCEL, 32'h000a);
    apb(1'b0, 8'h40, 32'h0);
    cmp("unmapped", 32'h1, {31'h0, er});
    wr(`RC_WRAP, 32'h40);
    for (int k = 0; k < 4; k++) begin
      wr(`RC_AXCFG5, k);
      apb(1'b0, `RC_STATUS, 32'h0);
      cmp("method_d", {31'h0, k[0]}, {31'h0, rd[2]});
    end
    wr(`RC_AXCFG5, 32'h1);
  endtask
  task automatic t_home();
    pq.delete();
    homing_mode <= 1'b1;
    @(posedge pclk) jog_plus_sel <= 1'b1;
    for (int i = 0; i < 8000 && home_done_flag !== 1'b1; i++) @(posedge pclk);
    jog_plus_sel <= 1'b0;
    homing_mode <= 1'b0;
    cmp("done", 32'h1, {31'h0, home_done_flag});
    cmp("pulses", 32'd12, pq.size());
    cmp("rapid_gap", 32'd125, pq[1] - pq[0]);
    cmp("low_gap", 32'd200, pq[11] - pq[10]);
    rdc("abs", `RC_ABS, 32'h0);
  endtask
  task automatic t_wrap();
    pq.delete();
    wr(`RC_TRAVEL, 32'h4);
    wr(`RC_WRAP, 32'h41);
    wr(`RC_MOVE, 32'h6);
    wr(`RC_CTRL, 32'h3);
    idle();
    cmp("moves", 32'd6, pq.size());
    rdc("abs", `RC_ABS, 32'h2);
    rdc("rel", `RC_REL, 32'h6);
    rdc("mach_a", `RC_MACH, 32'h2);
    wr(`RC_AXCFG5, 32'h3);
    wr(`RC_CTRL, 32'h3);
    idle();
    rdc("mach_b", `RC_MACH, 32'h8);
    pq.delete();
    wr(`RC_LASH, 32'h2);
    wr(`RC_MOVE, 32'h3);
    wr(`RC_CTRL, 32'h1);
    idle();
    cmp("lash_pulses", 32'd5, pq.size());
    cmp("dir", 32'h0, {31'h0, cmd_dir});
    rdc("mach_lash", `RC_MACH, 32'h5);
    wr(`RC_LASH, 32'h0);
    wr(`RC_TRAVEL, 32'h8ca0);
  endtask
  task automatic t_contour();
    wr(`RC_AXCFG5, 32'h21);
    wr(`RC_AXCFG4, 32'h21);
    apb(1'b0, `RC_STATUS, 32'h0);
    cmp("cs_excl", 32'h1, {30'h0, rd[1:0]});
    wr(`RC_AXCFG4, 32'h20);
    apb(1'b0, `RC_STATUS, 32'h0);
    cmp("cs_rot", 32'h2, {30'h0, rd[1:0]});
    wr(`RC_CTRL, 32'h1);
    rdc("alarm", `RC_ALARM, 32'h2);
    wr(`RC_ALARM, 32'hf);
    spin_cmd <= 1'b1;
    @(posedge pclk) contour_mode_request <= 1'b1;
    for (int i = 0; i < 20 && spindle_stop_req !== 1'b1; i++) @(posedge pclk);
    cmp("stop_req", 32'h1, {31'h0, spindle_stop_req});
    cmp("ack_early", 32'h0, {31'h0, contour_mode_ack});
    for (int i = 0; i < 50 && contour_mode_ack !== 1'b1; i++) @(posedge pclk);
    cmp("ack", 32'h1, {31'h0, contour_mode_ack});
    cmp("done_clr", 32'h0, {31'h0, home_done_flag});
    wr(`RC_CTRL, 32'h1);
    rdc("alarm", `RC_ALARM, 32'h4);
    wr(`RC_ALARM, 32'hf);
    pq.delete();
    wr(`RC_MOVE, 32'h2);
    wr(`RC_CTRL, 32'h6);
    idle();
    cmp("ahome_pulses", 32'd9, pq.size());
    cmp("ahome_done", 32'h1, {31'h0, home_done_flag});
    rdc("ahome_mach", `RC_MACH, 32'h0);
    spin_cmd <= 1'b0;
    @(posedge pclk) spin_cmd <= 1'b1;
    @(posedge pclk) contour_mode_request <= 1'b0;
    repeat (8) @(posedge pclk);
    cmp("ack_off", 32'h0, {31'h0, contour_mode_ack});
    rdc("alarm", `RC_ALARM, 32'h1);
  endtask
  task automatic conclude();
    if (err_total == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #120000;
    err_total++;
    conclude();
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_home();
    t_wrap();
    t_contour();
    conclude();
  end
endmodule
